// [clock_generation_pkg.sv]
// package: register map, field layout, reset values and carrier types of the clock generation block
package clock_generation_pkg;
  // register byte addresses
  localparam logic [7:0] clock_control_addr      = 8'h00;
  localparam logic [7:0] loop_frequency_addr     = 8'h04;
  localparam logic [7:0] port_f_select_addr      = 8'h08;
  localparam logic [7:0] power_control_addr      = 8'h0c;
  localparam logic [7:0] status_addr             = 8'h10;
  // clock control register fields
  localparam int first_divider_bit               = 0;
  localparam int second_divider_bit              = 1;
  localparam int panel_select_lsb                = 2;
  localparam int system_select_lsb               = 5;
  localparam int select_width                    = 3;
  localparam int clock_enable_bit                = 8;
  localparam int sleep_bit                       = 9;
  localparam logic [31:0] clock_control_reset    = 32'h0000_0081;
  localparam logic [31:0] clock_control_mask     = 32'h0000_03ff;
  // loop frequency select fields
  localparam int coarse_lsb                      = 0;
  localparam int coarse_width                    = 8;
  localparam int fine_lsb                        = 8;
  localparam int fine_width                      = 4;
  localparam int ref_level_bit                   = 15;
  localparam logic [31:0] loop_frequency_reset   = 32'h0000_0347;
  localparam logic [31:0] loop_frequency_mask    = 32'h0000_0fff;
  localparam int fine_limit                      = 14;
  // port f function select
  localparam int clock_out_select_bit            = 2;
  localparam logic [31:0] port_f_select_reset    = 32'h0000_0087;
  localparam logic [31:0] port_f_select_mask     = 32'h0000_00ff;
  // power control fields
  localparam int burst_width_lsb                 = 0;
  localparam int burst_width_bits                = 5;
  localparam int burst_enable_bit                = 5;
  localparam int doze_bit                        = 6;
  localparam logic [31:0] power_control_reset    = 32'h0000_001f;
  localparam logic [31:0] power_control_mask     = 32'h0000_007f;
  // status fields
  localparam int multiplier_lsb                  = 0;
  localparam int multiplier_width                = 16;
  localparam int factors_valid_bit               = 16;
  localparam int mode_lsb                        = 20;
  // stages of the divider chain
  localparam int stage_count                     = 5;
  localparam int stage_loop                      = 0;
  localparam int stage_first                     = 1;
  localparam int stage_fetch                     = 2;
  localparam int stage_panel                     = 3;
  localparam int stage_system                    = 4;
  localparam int half_width                      = 8;
  localparam logic [half_width-1:0] loop_half    = 8'h01;
  localparam logic [1:0] resp_okay               = 2'h0;
  localparam logic [1:0] resp_slverr             = 2'h2;

  typedef enum logic [3:0] {
    mode_run   = 4'h1,
    mode_burst = 4'h2,
    mode_doze  = 4'h4,
    mode_sleep = 4'h8
  } power_mode_type;

  // clocks handed to each consumer
  typedef struct packed {
    logic ref_clock;
    logic system_clock;
    logic fetch_clock;
  } memory_clocks_type;

  typedef struct packed {
    logic system_clock;
    logic fetch_clock;
    logic panel_clock;
  } display_clocks_type;

  typedef struct packed {
    logic ref_clock;
    logic system_clock;
  } ref_sys_clocks_type;

  typedef struct packed {
    logic data;
    logic enable;
  } pin_drive_type;
endpackage

// [clock_generation_divider_chain.sv]
// file: clock generation divider chain with power control and register slave
`timescale 1ns/1ps

// Functional notes
// (RQ1) reference clock comes from crystal; feeds loop and many modules
// (RQ2) loop output frequency set by reference and coarse/fine factor fields; here the fields only set the status multiplier
// (RQ3) loop clock enters first prescaler, ratio chosen by first divider select
// (RQ4) first prescaler drives second; its ratio chosen by second divider select
// (RQ5) fetch clock drives display and sources panel and system dividers
// (RQ6) panel divider ratio chosen by panel select field
// (RQ7) panel clock goes only to display controller
// (RQ8) system clock clocks the processor and most modules
// (RQ9) only system clock may go out, via buffered clock-out pin
// (RQ10) clock-out drives only when clock enable set and port f bit 2 clear
// (RQ11) all generated clocks programmable except the fixed reference; here the loop output clock is fixed too, with a half period of loop_half
// (RQ12) route reference, system and fetch clocks to their listed consumers
// (RQ13) power control delivers processor clock in reduced-width bursts
// (RQ14) four power modes; sleep stops all clocks but the reference
// (RQ15) reference keeps running through sleep while others are off
// (RQ16) multiplier equals 2*(14*(P+1)+Q+1) with stated factor limits
// (RQ17) software keeps first prescaler at divide by two
// (RQ18) divider changes cause no shortened clock pulses
module clock_generation_divider_chain
  import clock_generation_pkg::*;
#(
  parameter int addr_width = 8
) (
  input  wire logic                  aclk,
  input  wire logic                  aresetn,
  input  wire logic [addr_width-1:0] s_axi_awaddr,
  input  wire logic                  s_axi_awvalid,
  output logic                       s_axi_awready,
  input  wire logic [31:0]           s_axi_wdata,
  input  wire logic [3:0]            s_axi_wstrb,
  input  wire logic                  s_axi_wvalid,
  output logic                       s_axi_wready,
  output logic [1:0]                 s_axi_bresp,
  output logic                       s_axi_bvalid,
  input  wire logic                  s_axi_bready,
  input  wire logic [addr_width-1:0] s_axi_araddr,
  input  wire logic                  s_axi_arvalid,
  output logic                       s_axi_arready,
  output logic [31:0]                s_axi_rdata,
  output logic [1:0]                 s_axi_rresp,
  output logic                       s_axi_rvalid,
  input  wire logic                  s_axi_rready,
  input  wire logic                  crystal_oscillator,
  input  wire logic                  wake_event,
  output logic                       low_freq_ref_clock,
  output logic                       loop_output_clock,
  output logic                       first_stage_clock,
  output logic                       display_fetch_clock,
  output logic                       panel_ref_clock,
  output logic                       system_core_clock,
  output logic                       processor_clock,
  output memory_clocks_type          memory_ctrl_clocks,
  output display_clocks_type         display_ctrl_clocks,
  output logic                       power_ctrl_ref_clock,
  output ref_sys_clocks_type         pwm_clocks,
  output ref_sys_clocks_type         timer_clocks,
  output logic                       rtc_ref_clock,
  output logic                       spi_system_clock,
  output logic                       uart_system_clock,
  output pin_drive_type              clock_out_pin
);

  // divide ratio tables, expressed as half periods in source half periods
  function automatic logic [half_width-1:0] post_divider(input logic [select_width-1:0] sel);
    case (sel)
      3'h0:    post_divider = 8'h02;
      3'h1:    post_divider = 8'h04;
      3'h2:    post_divider = 8'h08;
      3'h3:    post_divider = 8'h10;
      3'h4:    post_divider = 8'h01;
      default: post_divider = 8'h01;
    endcase
  endfunction

  function automatic logic [multiplier_width-1:0] loop_multiplier(input logic [coarse_width-1:0] p,
                                                                   input logic [fine_width-1:0]   q);
    logic [multiplier_width-1:0] sum;
    sum = 16'(fine_limit) * (16'(p) + 16'h0001) + 16'(q) + 16'h0001;
    loop_multiplier = 16'(sum << 1);
  endfunction

  // register state
  logic [31:0] clock_control_reg, next_clock_control_reg;
  logic [31:0] loop_frequency_select_reg, next_loop_frequency_select_reg;
  logic [31:0] port_f_function_select, next_port_f_function_select;
  logic [31:0] power_control_reg, next_power_control_reg;
  logic        aw_held, next_aw_held;
  logic        w_held, next_w_held;
  logic [addr_width-1:0] aw_addr, next_aw_addr;
  logic [31:0] w_data, next_w_data;
  logic [3:0]  w_strb, next_w_strb;
  logic        bvalid, next_bvalid;
  logic [1:0]  bresp, next_bresp;
  logic        rvalid, next_rvalid;
  logic [1:0]  rresp, next_rresp;
  logic [31:0] rdata, next_rdata;
  // chain state
  logic [half_width-1:0] stage_count_q [stage_count];
  logic [half_width-1:0] next_stage_count [stage_count];
  logic [half_width-1:0] stage_half [stage_count];
  logic [half_width-1:0] next_stage_half [stage_count];
  logic [half_width-1:0] target_half [stage_count];
  logic [stage_count-1:0] stage_out, next_stage_out;
  logic        ref_level, next_ref_level;
  logic [burst_width_bits-1:0] burst_count, next_burst_count;
  logic        proc_clock, next_proc_clock;
  logic        pin_data, next_pin_data;
  logic        pin_enable, next_pin_enable;
  power_mode_type mode, next_mode;
  logic        write_fire;
  logic [31:0] write_mask;
  logic        sleeping;
  logic [multiplier_width-1:0] multiplier;
  logic        factors_valid;

  assign sleeping   = clock_control_reg[sleep_bit];
  assign write_fire = aw_held && w_held && !bvalid;
  assign write_mask = {{8{w_strb[3]}}, {8{w_strb[2]}}, {8{w_strb[1]}}, {8{w_strb[0]}}};
  assign multiplier = loop_multiplier(loop_frequency_select_reg[coarse_lsb +: coarse_width],
                                      loop_frequency_select_reg[fine_lsb +: fine_width]); // see (RQ16)
  // factor limits: 1 < q < 14 and p > q + 1
  assign factors_valid = (loop_frequency_select_reg[fine_lsb +: fine_width] > 4'h1)
                      && (loop_frequency_select_reg[fine_lsb +: fine_width] < 4'(fine_limit))
                      && (loop_frequency_select_reg[coarse_lsb +: coarse_width]
                          > 8'(loop_frequency_select_reg[fine_lsb +: fine_width]) + 8'h01);

  // bus slave: address and data taken in either order, answer after both
  always_comb begin
    next_aw_held = aw_held;
    next_w_held  = w_held;
    next_aw_addr = aw_addr;
    next_w_data  = w_data;
    next_w_strb  = w_strb;
    next_bvalid  = bvalid;
    next_bresp   = bresp;
    next_rvalid  = rvalid;
    next_rresp   = rresp;
    next_rdata   = rdata;
    next_clock_control_reg         = clock_control_reg;
    next_loop_frequency_select_reg = loop_frequency_select_reg;
    next_port_f_function_select    = port_f_function_select;
    next_power_control_reg         = power_control_reg;
    if (s_axi_awvalid && !aw_held) begin
      next_aw_held = 1'b1;
      next_aw_addr = s_axi_awaddr;
    end
    if (s_axi_wvalid && !w_held) begin
      next_w_held = 1'b1;
      next_w_data = s_axi_wdata;
      next_w_strb = s_axi_wstrb;
    end
    if (write_fire) begin
      next_aw_held = 1'b0;
      next_w_held  = 1'b0;
      next_bvalid  = 1'b1;
      next_bresp   = resp_okay;
      case (8'(aw_addr))
        clock_control_addr: next_clock_control_reg =
          ((clock_control_reg & ~write_mask) | (w_data & write_mask)) & clock_control_mask; // see (RQ11)
        loop_frequency_addr: next_loop_frequency_select_reg =
          ((loop_frequency_select_reg & ~write_mask) | (w_data & write_mask)) & loop_frequency_mask; // see (RQ2)
        port_f_select_addr: next_port_f_function_select =
          ((port_f_function_select & ~write_mask) | (w_data & write_mask)) & port_f_select_mask;
        power_control_addr: next_power_control_reg =
          ((power_control_reg & ~write_mask) | (w_data & write_mask)) & power_control_mask;
        status_addr: next_bresp = resp_okay;  // read-only, write ignored
        default: next_bresp = resp_slverr;
      endcase
    end
    if (bvalid && s_axi_bready) begin
      next_bvalid = 1'b0;
    end
    // wake event ends sleep; it wins over a software write in the same cycle
    if (wake_event) begin
      next_clock_control_reg[sleep_bit] = 1'b0; // see (RQ14)
    end
    if (s_axi_arvalid && !rvalid) begin
      next_rvalid = 1'b1;
      next_rresp  = resp_okay;
      case (8'(s_axi_araddr))
        clock_control_addr:  next_rdata = clock_control_reg;
        loop_frequency_addr: next_rdata = loop_frequency_select_reg | (32'(ref_level) << ref_level_bit);
        port_f_select_addr:  next_rdata = port_f_function_select;
        power_control_addr:  next_rdata = power_control_reg;
        status_addr:         next_rdata = 32'(multiplier) | (32'(factors_valid) << factors_valid_bit)
                                        | (32'(mode) << mode_lsb);
        default: begin
          next_rdata = 32'h0000_0000;
          next_rresp = resp_slverr;
        end
      endcase
    end else if (rvalid && s_axi_rready) begin
      next_rvalid = 1'b0;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_held <= 1'b0;
      w_held  <= 1'b0;
      aw_addr <= '0;
      w_data  <= 32'h0000_0000;
      w_strb  <= 4'h0;
      bvalid  <= 1'b0;
      bresp   <= resp_okay;
      rvalid  <= 1'b0;
      rresp   <= resp_okay;
      rdata   <= 32'h0000_0000;
      clock_control_reg         <= clock_control_reset;
      loop_frequency_select_reg <= loop_frequency_reset;
      port_f_function_select    <= port_f_select_reset;
      power_control_reg         <= power_control_reset;
    end else begin
      aw_held <= next_aw_held;
      w_held  <= next_w_held;
      aw_addr <= next_aw_addr;
      w_data  <= next_w_data;
      w_strb  <= next_w_strb;
      bvalid  <= next_bvalid;
      bresp   <= next_bresp;
      rvalid  <= next_rvalid;
      rresp   <= next_rresp;
      rdata   <= next_rdata;
      clock_control_reg         <= next_clock_control_reg;
      loop_frequency_select_reg <= next_loop_frequency_select_reg;
      port_f_function_select    <= next_port_f_function_select;
      power_control_reg         <= next_power_control_reg;
    end
  end

  // requested half periods in aclk cycles; aclk stands in for the locked loop
  always_comb begin
    target_half[stage_loop]   = loop_half;
    target_half[stage_first]  = clock_control_reg[first_divider_bit] ? 8'h02 : 8'h01; // see (RQ3) (RQ17)
    target_half[stage_fetch]  = 8'(target_half[stage_first]
                                   << clock_control_reg[second_divider_bit]); // see (RQ4)
    target_half[stage_panel]  = 8'(target_half[stage_fetch]
                                   * post_divider(clock_control_reg[panel_select_lsb +: select_width])); // see (RQ6)
    target_half[stage_system] = 8'(target_half[stage_fetch]
                                   * post_divider(clock_control_reg[system_select_lsb +: select_width])); // see (RQ5)
  end

  // each stage toggles after its half period; a new ratio is taken only at a period end while the output
  // is low, and a stop at any point while the output is low, so no pulse is ever cut short
  always_comb begin
    for (int i = 0; i < stage_count; i++) begin
      next_stage_count[i] = stage_count_q[i];
      next_stage_out[i]   = stage_out[i];
      next_stage_half[i]  = stage_half[i];
      if (!stage_out[i] && stage_count_q[i] == 8'h00) begin
        next_stage_half[i] = target_half[i]; // see (RQ18)
      end
      if (stage_out[i] || !sleeping) begin // see (RQ14)
        if (stage_count_q[i] + 8'h01 >= next_stage_half[i]) begin
          next_stage_count[i] = 8'h00;
          next_stage_out[i]   = !stage_out[i];
        end else begin
          next_stage_count[i] = stage_count_q[i] + 8'h01;
        end
      end
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      for (int i = 0; i < stage_count; i++) begin
        stage_count_q[i] <= 8'h00;
        stage_half[i]    <= 8'h01;
      end
      stage_out <= '0;
    end else begin
      for (int i = 0; i < stage_count; i++) begin
        stage_count_q[i] <= next_stage_count[i];
        stage_half[i]    <= next_stage_half[i];
      end
      stage_out <= next_stage_out;
    end
  end

  // power mode, burst gating of the processor clock and the clock-out pin
  always_comb begin
    next_ref_level   = crystal_oscillator; // see (RQ1) (RQ15)
    next_burst_count = burst_count;
    if (sleeping) begin
      next_mode = mode_sleep;
    end else if (power_control_reg[doze_bit]) begin
      next_mode = mode_doze;
    end else if (power_control_reg[burst_enable_bit]) begin
      next_mode = mode_burst;
    end else begin
      next_mode = mode_run;
    end
    // count system periods on the rising edge of the system clock
    if (next_stage_out[stage_system] && !stage_out[stage_system]) begin
      next_burst_count = 5'(burst_count + 5'h01);
    end
    next_proc_clock = 1'b0;
    // gate only changes while the system clock is low, so bursts are whole pulses
    if (next_stage_out[stage_system]) begin
      case (mode)
        mode_run:   next_proc_clock = 1'b1;
        mode_burst: next_proc_clock = (next_burst_count <= power_control_reg[burst_width_lsb +: burst_width_bits])
                                      || proc_clock; // see (RQ13)
        mode_doze:  next_proc_clock = 1'b0;
        mode_sleep: next_proc_clock = 1'b0;
        default:    next_proc_clock = 1'b0;
      endcase
    end
    next_pin_enable = clock_control_reg[clock_enable_bit]
                   && !port_f_function_select[clock_out_select_bit]; // see (RQ10)
    next_pin_data   = next_pin_enable && next_stage_out[stage_system]; // see (RQ9)
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      ref_level   <= 1'b0;
      burst_count <= '0;
      proc_clock  <= 1'b0;
      mode        <= mode_run;
      pin_data    <= 1'b0;
      pin_enable  <= 1'b0;
    end else begin
      ref_level   <= next_ref_level;
      burst_count <= next_burst_count;
      proc_clock  <= next_proc_clock;
      mode        <= next_mode;
      pin_data    <= next_pin_data;
      pin_enable  <= next_pin_enable;
    end
  end

  // bus outputs
  assign s_axi_awready = !aw_held;
  assign s_axi_wready  = !w_held;
  assign s_axi_bvalid  = bvalid;
  assign s_axi_bresp   = bresp;
  assign s_axi_arready = !rvalid;
  assign s_axi_rvalid  = rvalid;
  assign s_axi_rresp   = rresp;
  assign s_axi_rdata   = rdata;

  // clock distribution, each consumer only what it is entitled to
  assign low_freq_ref_clock  = ref_level;
  assign loop_output_clock   = stage_out[stage_loop];
  assign first_stage_clock   = stage_out[stage_first];
  assign display_fetch_clock = stage_out[stage_fetch];
  assign panel_ref_clock     = stage_out[stage_panel];
  assign system_core_clock   = stage_out[stage_system];
  assign processor_clock     = proc_clock; // see (RQ8)
  assign memory_ctrl_clocks  = '{ref_clock: ref_level, system_clock: stage_out[stage_system],
                                 fetch_clock: stage_out[stage_fetch]}; // see (RQ12)
  assign display_ctrl_clocks = '{system_clock: stage_out[stage_system], fetch_clock: stage_out[stage_fetch],
                                 panel_clock: stage_out[stage_panel]}; // see (RQ7)
  assign power_ctrl_ref_clock = ref_level;
  assign pwm_clocks          = '{ref_clock: ref_level, system_clock: stage_out[stage_system]};
  assign timer_clocks        = '{ref_clock: ref_level, system_clock: stage_out[stage_system]};
  assign rtc_ref_clock       = ref_level;
  assign spi_system_clock    = stage_out[stage_system];
  assign uart_system_clock   = stage_out[stage_system];
  assign clock_out_pin       = '{data: pin_data, enable: pin_enable};

endmodule // clock_generation_divider_chain

// [clock_generation_asserts.sv]
// checker: port-level assertions of the clock generation divider chain
`timescale 1ns/1ps
module clock_generation_asserts
  import clock_generation_pkg::*;
(
  input wire logic               aclk,
  input wire logic               aresetn,
  input wire logic               s_axi_awvalid,
  input wire logic               s_axi_awready,
  input wire logic               s_axi_wvalid,
  input wire logic               s_axi_wready,
  input wire logic               s_axi_bvalid,
  input wire logic               s_axi_bready,
  input wire logic               s_axi_arvalid,
  input wire logic               s_axi_arready,
  input wire logic               s_axi_rvalid,
  input wire logic               crystal_oscillator,
  input wire logic               low_freq_ref_clock,
  input wire logic               display_fetch_clock,
  input wire logic               panel_ref_clock,
  input wire logic               system_core_clock,
  input wire memory_clocks_type  memory_ctrl_clocks,
  input wire display_clocks_type display_ctrl_clocks,
  input wire logic               rtc_ref_clock,
  input wire logic               spi_system_clock,
  input wire logic               uart_system_clock,
  input wire pin_drive_type      clock_out_pin
);
  default clocking @(posedge aclk); endclocking
  default disable iff (!aresetn);
  // first edge after release still sees the reset-time reference
  chk_ref_follow: assert property ($past(aresetn) |-> low_freq_ref_clock == $past(crystal_oscillator))
    else $error("reference clock does not follow the crystal");
  chk_pin_quiet: assert property (!clock_out_pin.enable |-> !clock_out_pin.data)
    else $error("clock-out data while not driving");
  chk_panel_only: assert property (display_ctrl_clocks.panel_clock == panel_ref_clock)
    else $error("panel clock route broken");
  chk_fetch_route: assert property (memory_ctrl_clocks.fetch_clock == display_fetch_clock
    && display_ctrl_clocks.fetch_clock == display_fetch_clock)
    else $error("fetch clock route broken");
  chk_sys_route: assert property (spi_system_clock == system_core_clock
    && uart_system_clock == system_core_clock && memory_ctrl_clocks.system_clock == system_core_clock)
    else $error("system clock route broken");
  chk_ref_route: assert property (rtc_ref_clock == low_freq_ref_clock
    && memory_ctrl_clocks.ref_clock == low_freq_ref_clock)
    else $error("reference clock route broken");
  chk_write_answer: assert property (s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready
    |-> ##[1:2] s_axi_bvalid)
    else $error("write response late");
  chk_read_answer: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
    else $error("read response late");
  cover property (s_axi_bvalid && s_axi_bready);
  cover property (clock_out_pin.enable);
  cover property ($rose(system_core_clock));
endmodule // clock_generation_asserts

bind clock_generation_divider_chain clock_generation_asserts u_clock_generation_asserts (.*);

// [test_clock_generation_divider_chain.sv]
// testbench: register access, divider ratios, clock-out gating and sleep
`timescale 1ns/1ps
module test_clock_generation_divider_chain
  import clock_generation_pkg::*;
;
  logic          aclk;
  logic          aresetn = 1'b0, crystal_oscillator = 1'b0, wake_event = 1'b0;
  logic [7:0]    s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00;
  logic [31:0]   s_axi_wdata = 32'h0, s_axi_rdata, rd, p;
  logic [3:0]    s_axi_wstrb = 4'hf;
  logic          s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_arvalid = 1'b0;
  logic          s_axi_bready = 1'b1, s_axi_rready = 1'b1;
  logic          s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  logic [1:0]    s_axi_bresp, s_axi_rresp, rs, xc = 2'h0;
  logic          low_freq_ref_clock, loop_output_clock, first_stage_clock, display_fetch_clock;
  logic          panel_ref_clock, system_core_clock, processor_clock;
  pin_drive_type clock_out_pin;
  int            fails = 0, n_checks = 0, hi, tg, i;
  int            dv [5] = '{2, 4, 8, 16, 1};
  wire [3:0]     clk_v = {processor_clock, panel_ref_clock, system_core_clock, display_fetch_clock};

  clock_generation_divider_chain u_clock_generation_divider_chain (.*, .memory_ctrl_clocks(),
    .display_ctrl_clocks(), .power_ctrl_ref_clock(), .pwm_clocks(), .timer_clocks(), .rtc_ref_clock(),
    .spi_system_clock(), .uart_system_clock());

  // clock and a crystal stand-in with a half period of four cycles
  initial begin
    aclk = 1'b0;
    forever #4 aclk = ~aclk;
  end
  always @(posedge aclk) begin
    xc <= xc + 2'h1;
    if (xc == 2'h3) crystal_oscillator <= ~crystal_oscillator;
  end

  task print_verdict;
    $display("checks %0d mismatches %0d", n_checks, fails);
    if (fails == 0 && n_checks > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask
  task chk(input logic [31:0] g, input logic [31:0] e);
    n_checks++;
    if (g !== e) begin
      fails++;
      $display("mismatch at %0t: got %h expected %h", $time, g, e);
    end
  endtask
  // write: both channels offered together, each released once taken
  task wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] e);
    logic ad, wd;
    ad = 0;
    wd = 0;
    rs = 2'h3;
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    for (int n = 0; n < 60 && rs === 2'h3; n++) begin
      @(posedge aclk);
      if (ad && wd && s_axi_bvalid) rs = s_axi_bresp;
      ad = ad | s_axi_awready;
      wd = wd | s_axi_wready;
      s_axi_awvalid <= !ad;
      s_axi_wvalid <= !wd;
    end
    chk(rs, e);
  endtask
  task rdchk(input logic [7:0] a, input logic [31:0] e, input logic [31:0] m);
    logic ad;
    ad = 0;
    rs = 2'h3;
    rd = '0;
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    for (int n = 0; n < 60 && rs === 2'h3; n++) begin
      @(posedge aclk);
      if (ad && s_axi_rvalid) begin
        rd = s_axi_rdata;
        rs = s_axi_rresp;
      end
      ad = ad | s_axi_arready;
      s_axi_arvalid <= !ad;
    end
    chk(rd & m, e);
  endtask
  // period in cycles between two rising edges of one generated clock
  task per(input int k);
    int c;
    logic pv;
    pv = 1'b1;
    c = 0;
    p = 0;
    for (int n = 0; n < 400 && c < 2; n++) begin
      @(posedge aclk);
      if (c == 1) p++;
      if (!pv && clk_v[k]) c++;
      pv = clk_v[k];
    end
  endtask
  function automatic logic [31:0] mult(input int pc, input int qc);
    return 32'(2 * (14 * (pc + 1) + qc + 1));
  endfunction

  // main sequence
  initial begin
    repeat (3) @(posedge aclk);
    aresetn <= 1'b1;
    @(posedge aclk);
    rdchk(clock_control_addr, 32'h081, 32'hffffffff);
    rdchk(loop_frequency_addr, 32'h347, 32'hffff7fff);
    rdchk(port_f_select_addr, 32'h087, 32'hffffffff);
    rdchk(power_control_addr, 32'h01f, 32'hffffffff);
    rdchk(status_addr, 32'h0011_07e8, 32'hffffffff);
    wr(8'h20, 32'h1, resp_slverr);
    rdchk(8'h20, 32'h0, 32'hffffffff);
    chk(rs, resp_slverr);
    wr(status_addr, 32'hffffffff, resp_okay);
    wr(loop_frequency_addr, 32'h041b, resp_okay);
    rdchk(status_addr, 32'h0001_0000 | mult(27, 4), 32'h0001ffff);
    wr(loop_frequency_addr, 32'h0e1b, resp_okay);
    rdchk(status_addr, mult(27, 14), 32'h0001ffff);
    // panel and system selects 0 to 4, measured after the change lands
    for (i = 0; i < 5; i++) begin
      wr(clock_control_addr, 32'h001 | (i << 2) | (i << 5), resp_okay);
      per(1);
      per(1);
      chk(p, 32'(4 * dv[i]));
      per(2);
      chk(p, 32'(4 * dv[i]));
      per(0);
      chk(p, 32'h4);
    end
    wr(clock_control_addr, 32'h083, resp_okay);
    per(0);
    per(0);
    chk(p, 32'h8);
    per(1);
    chk(p, 32'h8);
    wr(clock_control_addr, 32'h181, resp_okay);
    repeat (4) @(posedge aclk);
    chk(clock_out_pin.enable, 1'b0);
    wr(port_f_select_addr, 32'h083, resp_okay);
    repeat (4) @(posedge aclk);
    chk(clock_out_pin.enable, 1'b1);
    hi = 0;
    repeat (8) begin
      @(posedge aclk);
      hi += int'(clock_out_pin.data);
    end
    chk(hi, 4);
    wr(clock_control_addr, 32'h081, resp_okay);
    repeat (4) @(posedge aclk);
    chk(clock_out_pin.enable, 1'b0);
    // sleep: generated clocks held low, reference keeps running
    wr(clock_control_addr, 32'h281, resp_okay);
    repeat (40) @(posedge aclk);
    hi = 0;
    tg = 0;
    repeat (64) begin
      @(posedge aclk);
      hi += int'(|clk_v);
      tg += int'(low_freq_ref_clock);
    end
    chk(hi, 0);
    chk(tg, 32);
    rdchk(status_addr, 32'h0080_0000, 32'h00f0_0000);
    wake_event <= 1'b1;
    @(posedge aclk);
    wake_event <= 1'b0;
    rdchk(clock_control_addr, 32'h081, 32'h3ff);
    per(1);
    per(1);
    chk(p, 32'h4);
    wr(power_control_addr, 32'h021, resp_okay);
    per(1);
    hi = 0;
    repeat (128) begin
      @(posedge aclk);
      hi += int'(processor_clock);
    end
    chk(hi, 4);
    print_verdict;
  end

  // watchdog against a hung handshake
  initial begin
    repeat (20000) @(posedge aclk);
    fails++;
    print_verdict;
  end
endmodule // test_clock_generation_divider_chain
